/* File: verilog/nsx_pkg.sv */
/*
 Package for the nibble-swap / xor / timer-mode datapath slice.
 Assumes a core that decodes instructions and supplies file register data.
*/
package nsx_pkg;
    localparam int NSX_DATA_W     = 8;
    localparam int NSX_ADDR_W     = 6;
    localparam logic [7:0] NSX_W_RESET  = 8'h00;
    localparam logic [7:0] NSX_TM_RESET = 8'h00;
    localparam logic       NSX_Z_RESET  = 1'b0;
    localparam int NSX_NIB_LO     = 0;
    localparam int NSX_NIB_HI     = 4;
    localparam logic NSX_DEST_W   = 1'b0;
    localparam logic NSX_DEST_F   = 1'b1;

    typedef enum logic [2:0] {
        NSX_OP_NONE = 3'b000,
        NSX_OP_SWAP = 3'b001,
        NSX_OP_LDTM = 3'b010,
        NSX_OP_RDTM = 3'b011,
        NSX_OP_XORI = 3'b100,
        NSX_OP_XORF = 3'b101
    } nsx_op_t;

    typedef struct packed {
        nsx_op_t    op;
        logic [5:0] faddr;
        logic       dest;
        logic [7:0] imm;
    } nsx_instr_t;

    typedef struct packed {
        logic       we;
        logic [5:0] addr;
        logic [7:0] data;
    } nsx_fwrite_t;
endpackage

/* File: verilog/nsx_datapath.sv */
/*
 Execution slice: nibble swap, xor immediate / file register, timer mode moves.
 Assumes one instruction per SYS_CLK while INSTR_VALID; file data is read
 combinationally at the supplied address and written by the core from FWR.
*/
`timescale 1ns/1ps
`default_nettype none
module nsx_datapath (
    input  wire logic                SYS_CLK,
    input  wire logic                ARST_N,
    input  wire logic                INSTR_VALID,
    input  wire nsx_pkg::nsx_instr_t INSTR,
    input  wire logic [7:0]          FILE_RDATA,
    output logic [5:0]               FILE_RADDR,
    output nsx_pkg::nsx_fwrite_t     FWR,
    output logic [7:0]               WORK_REG,
    output logic [7:0]               TMODE_REG,
    output logic                     ZERO_FLAG
);
    import nsx_pkg::*;

    // Decoded strobes, all gated by INSTR_VALID
    logic        do_swap;
    logic        do_xori;
    logic        do_xorf;
    logic        do_rdtm;
    logic        do_ldtm;
    logic        to_file;
    logic        to_work;
    logic        set_zero;

    // Operand and result paths
    logic [7:0]  xor_lhs;
    logic [7:0]  xor_rhs;
    logic [7:0]  xor_out;
    logic [7:0]  swap_out;
    logic [7:0]  result;
    logic        result_zero;

    // State groups, each with its own next value
    logic [7:0]  w_reg;
    logic [7:0]  w_next;
    logic [7:0]  tm_reg;
    logic [7:0]  tm_next;
    logic        z_reg;
    logic        z_next;
    nsx_fwrite_t fw_reg;
    nsx_fwrite_t fw_next;

    function automatic logic [7:0] swap_nib(input logic [7:0] v);
        swap_nib = {v[NSX_NIB_LO +: 4], v[NSX_NIB_HI +: 4]};
    endfunction

    // Ops whose operand is the addressed file register
    function automatic logic op_reads_file(input nsx_op_t op);
        op_reads_file = (op == NSX_OP_SWAP) || (op == NSX_OP_XORF);
    endfunction

    // Swap and timer moves leave the zero flag alone
    function automatic logic op_sets_zero(input nsx_op_t op);
        op_sets_zero = (op == NSX_OP_XORI) || (op == NSX_OP_XORF);
    endfunction

    // Ops that load the working register whatever the dest bit
    function automatic logic op_fixed_work(input nsx_op_t op);
        op_fixed_work = (op == NSX_OP_XORI) || (op == NSX_OP_RDTM);
    endfunction

    assign FILE_RADDR = INSTR.faddr;

    // Instruction decode; codes 0, 6 and 7 fall through as no-ops
    always_comb begin
        do_swap  = 1'b0;
        do_xori  = 1'b0;
        do_xorf  = 1'b0;
        do_rdtm  = 1'b0;
        do_ldtm  = 1'b0;
        to_file  = 1'b0;
        to_work  = 1'b0;
        set_zero = 1'b0;
        if (INSTR_VALID) begin
            do_swap  = (INSTR.op == NSX_OP_SWAP);
            do_xori  = (INSTR.op == NSX_OP_XORI);
            do_xorf  = (INSTR.op == NSX_OP_XORF);
            do_rdtm  = (INSTR.op == NSX_OP_RDTM);
            do_ldtm  = (INSTR.op == NSX_OP_LDTM);

            // Dest bit only matters for file-operand ops
            if (op_reads_file(INSTR.op)) begin
                if (INSTR.dest == NSX_DEST_F) begin
                    to_file = 1'b1;
                end else begin
                    to_work = 1'b1;
                end
            end

            if (op_fixed_work(INSTR.op)) begin
                to_work = 1'b1;
            end
            set_zero = op_sets_zero(INSTR.op);
        end
    end

    // Immediate for xor-immediate, file data for xor-file
    always_comb begin
        xor_lhs = w_reg;
        if (do_xori) begin
            xor_rhs = INSTR.imm;
        end else begin
            xor_rhs = FILE_RDATA;
        end
    end

    // One xor cell per data bit
    genvar gi;
    generate
        for (gi = 0; gi < NSX_DATA_W; gi = gi + 1) begin : g_xor_bit
            assign xor_out[gi] = xor_lhs[gi] ^ xor_rhs[gi];
        end
    endgenerate

    // Pure move; no carry and no zero update
    assign swap_out = swap_nib(FILE_RDATA);

    // Result select; at most one op is active
    always_comb begin
        result = 8'h00;
        if (do_swap) begin
            result = swap_out;
        end else if (do_xori || do_xorf) begin
            result = xor_out;
        end else if (do_rdtm) begin
            result = tm_reg;
        end
    end

    assign result_zero = (result == 8'h00);

    // Working register
    always_comb begin
        w_next = w_reg;
        if (to_work) begin
            w_next = result;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            w_reg <= NSX_W_RESET;
        end else begin
            w_reg <= w_next;
        end
    end

    // Timer-0 mode register; field meaning lives in the timer
    always_comb begin
        tm_next = tm_reg;
        if (do_ldtm) begin
            tm_next = w_reg;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tm_reg <= NSX_TM_RESET;
        end else begin
            tm_reg <= tm_next;
        end
    end

    // Zero flag, from the result whichever way it is routed
    always_comb begin
        z_next = z_reg;
        if (set_zero) begin
            z_next = result_zero;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            z_reg <= NSX_Z_RESET;
        end else begin
            z_reg <= z_next;
        end
    end

    // File write strobe; the core performs the write a cycle later
    always_comb begin
        fw_next.we   = 1'b0;
        fw_next.addr = 6'h00;
        fw_next.data = 8'h00;
        if (to_file) begin
            fw_next.we   = 1'b1;
            fw_next.addr = INSTR.faddr;
            fw_next.data = result;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            fw_reg.we   <= 1'b0;
            fw_reg.addr <= 6'h00;
            fw_reg.data <= 8'h00;
        end else begin
            fw_reg <= fw_next;
        end
    end

    // Core must forward a same-address read in the next cycle
    assign FWR       = fw_reg;
    assign WORK_REG  = w_reg;
    assign TMODE_REG = tm_reg;
    assign ZERO_FLAG = z_reg;
endmodule // nsx_datapath
`default_nettype wire

/* File: test/nsx_props.sv */
/* Port checker for nsx_datapath; bound to every instance. */
`timescale 1ns/1ps
`default_nettype none
module nsx_props import nsx_pkg::*; (
    input wire logic        SYS_CLK,
    input wire logic        ARST_N,
    input wire logic        INSTR_VALID,
    input wire nsx_instr_t  INSTR,
    input wire logic [7:0]  FILE_RDATA,
    input wire logic [7:0]  WORK_REG,
    input wire logic [7:0]  TMODE_REG,
    input wire logic [5:0]  FILE_RADDR,
    input wire nsx_fwrite_t FWR,
    input wire logic        ZERO_FLAG
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    logic [2:0] o;
    assign o = INSTR_VALID ? INSTR.op : 3'h0;
    a_swap_nib: assert property (o == NSX_OP_SWAP && !INSTR.dest |=> WORK_REG ==
        {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])}) else $error("swap");
    a_dest_route: assert property (o == NSX_OP_SWAP || o == NSX_OP_XORF |=>
        FWR.we == $past(INSTR.dest)) else $error("dest");
    a_file_addr: assert property (o == NSX_OP_XORF && INSTR.dest |=>
        FWR.addr == $past(INSTR.faddr)) else $error("addr");
    a_load_tm: assert property (o == NSX_OP_LDTM |=>
        TMODE_REG == $past(WORK_REG)) else $error("ldtm");
    a_read_tm: assert property (o == NSX_OP_RDTM |=>
        WORK_REG == $past(TMODE_REG)) else $error("rdtm");
    a_xor_imm: assert property (o == NSX_OP_XORI |=> WORK_REG ==
        ($past(WORK_REG) ^ $past(INSTR.imm)) && ZERO_FLAG == (WORK_REG == 8'h00)) else $error("xi");
    a_xor_file: assert property (o == NSX_OP_XORF && INSTR.dest |=> FWR.data ==
        ($past(WORK_REG) ^ $past(FILE_RDATA)) && ZERO_FLAG == (FWR.data == 8'h00)) else $error("xf");
endmodule // nsx_props
bind nsx_datapath nsx_props u_props (.*);
`default_nettype wire

/* File: test/nsx_datapath_tb.sv */
/* Random instruction stream with a bench model; drives all ports itself. */
`timescale 1ns/1ps
`default_nettype none
module nsx_datapath_tb;
    import nsx_pkg::*;
    logic c = 0, r = 0, v = 0, z = 0, we, zf;
    logic [7:0] fd = 0, w = 0, t = 0, res, wr, tr;
    logic [5:0] ra;
    logic ez = 0, ewe = 0;
    logic [7:0] ew = 0, et = 0, er = 0;
    logic [5:0] ea = 0;
    nsx_instr_t i = '0, x;
    nsx_fwrite_t f;
    int s = 1, miscompares = 0, compares = 0, cyc = 0;
    always #12.5 c = ~c;
    nsx_datapath dut (.SYS_CLK(c), .ARST_N(r), .INSTR_VALID(v), .INSTR(i), .FILE_RDATA(fd),
        .FILE_RADDR(ra), .FWR(f), .WORK_REG(wr), .TMODE_REG(tr), .ZERO_FLAG(zf));
    task chk(input string n, input logic [7:0] e, g);
        compares++;
        if (e !== g) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task end_sim;
        $display("miscompares %0d compares %0d", miscompares, compares);
        if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge c) if (++cyc > 3000) begin
        miscompares++;
        end_sim;
    end
    initial begin
        we = 0;
        x = '0;
        repeat (2) @(posedge c);
        r <= 1;
        for (int n = 0; n < 600; n++) begin
            @(negedge c);
            chk("w", ew, wr);
            chk("tm", et, tr);
            chk("z", {7'h0, ez}, {7'h0, zf});
            chk("we", {7'h0, ewe}, {7'h0, f.we});
            chk("ra", {2'h0, x.faddr}, {2'h0, ra});
            if (ewe) chk("fw", er, f.data);
            if (ewe) chk("fa", {2'h0, ea}, {2'h0, f.addr});
            @(posedge c);
            // Design shows an instruction one edge after it is driven
            ew = w;
            et = t;
            ez = z;
            ewe = we;
            er = res;
            ea = x.faddr;
            x = {3'($random(s)), 6'($random(s)), 1'($random(s)), n[0] ? w : 8'($random(s))};
            res = n % 4 == 0 ? w : 8'($random(s));
            v <= n > 0; i <= x; fd <= res;
            we = 0;
            if (n > 0) case (x.op)
                NSX_OP_SWAP: begin res = {res[3:0], res[7:4]}; we = x.dest; end
                NSX_OP_LDTM: t = w;
                NSX_OP_RDTM: w = t;
                NSX_OP_XORI: begin w = w ^ x.imm; z = w == 8'h00; end
                NSX_OP_XORF: begin res = w ^ res; z = res == 8'h00; we = x.dest; end
                default: ;
            endcase
            if (n > 0 && !we && (x.op == NSX_OP_SWAP || x.op == NSX_OP_XORF)) w = res;
        end
        end_sim;
    end
endmodule // nsx_datapath_tb
`default_nettype wire
